/* File: hw/adp_pkg.sv */
// Package with register map, field layouts, reset values and mode codes of the digital path configuration block.
//
// Summary of operation
// - Rate enable clear gives full rate output.
// - Shape code applies when both enables set.
// - Codes 0,4,8,C: band-pass, decimate by four.
// - Codes 2,6: low/high-pass by two; 3: mixer IQ.
// - Band index picks correction band; others unused.
// - Band index used only with 4Eh bit 7.
// - Coding select: 0 twos complement, 1 offset.
// - Coding select needs its control enable.
// - Gain field scales samples: value over 32.
// - Gain applies only with 52h bit 0.
// - Settings take effect after page reset pulse.
// - Coding enable low keeps twos complement output.
// - Shape control enable low gives default behaviour.
package adp_pkg;

    // ========================================================================
    // Register offsets.
    localparam logic [7:0] ADDR_RESET    = 8'h00;
    localparam logic [7:0] ADDR_FILTER   = 8'h41;
    localparam logic [7:0] ADDR_BAND     = 8'h42;
    localparam logic [7:0] ADDR_CODING   = 8'h43;
    localparam logic [7:0] ADDR_GAIN     = 8'h44;
    localparam logic [7:0] ADDR_FMT_CTL  = 8'h4B;
    localparam logic [7:0] ADDR_DEC_CTL  = 8'h4D;
    localparam logic [7:0] ADDR_BAND_CTL = 8'h4E;
    localparam logic [7:0] ADDR_GAIN_CTL = 8'h52;
    localparam logic [7:0] ADDR_STATUS   = 8'h60;

    // ========================================================================
    // Field positions.
    localparam int BIT_PULSE      = 0;
    localparam int BIT_SHAPE_TOP  = 5;
    localparam int BIT_RATE_EN    = 4;
    localparam int BIT_FMT_EN     = 5;
    localparam int BIT_DEC_CTL_EN = 3;
    localparam int BIT_BAND_CTL   = 7;
    localparam int BIT_GAIN_EN    = 0;

    // Write masks: reserved bits are not stored and read as zero.
    localparam logic [7:0] MASK_RESET    = 8'h01;
    localparam logic [7:0] MASK_FILTER   = 8'h37;
    localparam logic [7:0] MASK_BAND     = 8'h07;
    localparam logic [7:0] MASK_CODING   = 8'h01;
    localparam logic [7:0] MASK_GAIN     = 8'h7F;
    localparam logic [7:0] MASK_FMT_CTL  = 8'h20;
    localparam logic [7:0] MASK_DEC_CTL  = 8'h08;
    localparam logic [7:0] MASK_BAND_CTL = 8'h80;
    localparam logic [7:0] MASK_GAIN_CTL = 8'h01;

    // Reset values.
    localparam logic [7:0] RST_REG   = 8'h00;
    localparam logic [6:0] GAIN_UNITY = 7'h20;
    localparam int         GAIN_SHIFT = 5;

    // ========================================================================
    // Filter shape codes.
    localparam logic [3:0] SHAPE_BP3  = 4'h0;
    localparam logic [3:0] SHAPE_BP5  = 4'h4;
    localparam logic [3:0] SHAPE_BP1  = 4'h8;
    localparam logic [3:0] SHAPE_BP7  = 4'hC;
    localparam logic [3:0] SHAPE_LP   = 4'h2;
    localparam logic [3:0] SHAPE_HP   = 4'h6;
    localparam logic [3:0] SHAPE_LPIQ = 4'h3;

    localparam logic [2:0] BAND_FIRST  = 3'h0;
    localparam logic [2:0] BAND_SECOND = 3'h1;
    localparam logic [2:0] BAND_THIRD  = 3'h2;

    typedef enum logic [2:0] {
        ADP_FILT_FULL, ADP_FILT_BP3, ADP_FILT_BP5, ADP_FILT_BP1,
        ADP_FILT_BP7, ADP_FILT_LP, ADP_FILT_HP, ADP_FILT_LPIQ
    } adp_filter_t;

    localparam logic [2:0] DECIM_ONE  = 3'h1;
    localparam logic [2:0] DECIM_TWO  = 3'h2;
    localparam logic [2:0] DECIM_FOUR = 3'h4;

    localparam int SAMPLE_W = 14;

endpackage

/* File: hw/adp_buf2.sv */
// Two-entry valid/ready buffer for output samples.
`timescale 1ns/10ps
module adp_buf2 #(
    parameter int WIDTH = 14
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wr_q;
    logic             rd_q;
    logic [1:0]       cnt_q;
    logic             push;
    logic             pop;

    // ========================================================================
    // Handshake terms; full and empty come straight from the count.
    assign in_ready_out  = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = mem_q[rd_q];

    // Storage is written only on push, so no reset is needed on the data.
    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // Pointers and count.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // adp_buf2

/* File: hw/adp_digital_path.sv */
// Digital path configuration registers with the sample path they steer.
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module adp_digital_path (
    input  wire logic                         clock_in,
    input  wire logic                         rst_in,
    input  wire logic [7:0]                   addr_in,
    input  wire logic [7:0]                   wdata_in,
    input  wire logic                         wr_in,
    input  wire logic                         rd_in,
    output logic      [7:0]                   rdata_out,
    input  wire logic                         smp_valid_in,
    output logic                              smp_ready_out,
    input  wire logic [adp_pkg::SAMPLE_W-1:0] smp_data_in,
    output logic                              out_valid_out,
    input  wire logic                         out_ready_in,
    output logic      [adp_pkg::SAMPLE_W-1:0] out_data_out,
    output logic      [2:0]                   filter_sel_out,
    output logic      [2:0]                   decim_out,
    output logic      [2:0]                   band_out,
    output logic                              band_valid_out,
    output logic                              offset_bin_out
);
    // ========================================================================
    // Shadow registers written by software.
    logic [7:0] pulse_q;
    logic [7:0] filter_q;
    logic [7:0] band_q;
    logic [7:0] coding_q;
    logic [7:0] gain_q;
    logic [7:0] fmt_ctl_q;
    logic [7:0] dec_ctl_q;
    logic [7:0] band_ctl_q;
    logic [7:0] gain_ctl_q;

    // Active copies that the sample path uses.
    logic [7:0] a_filter_q;
    logic [7:0] a_band_q;
    logic [7:0] a_coding_q;
    logic [7:0] a_gain_q;
    logic       a_fmt_en_q;
    logic       a_dec_en_q;
    logic       a_band_en_q;
    logic       a_gain_en_q;
    logic       apply;

    logic                         wr_filter;
    adp_pkg::adp_filter_t         filt_d;
    logic [2:0]                   decim_d;
    logic [3:0]                   shape;
    logic [2:0]                   keep_cnt_q;
    logic                         keep;
    logic [adp_pkg::SAMPLE_W-1:0] fmt_smp;
    logic [adp_pkg::SAMPLE_W+6:0] prod;
    logic [adp_pkg::SAMPLE_W-1:0] scaled;
    logic                         buf_ready;
    logic                         stage_valid_q;
    logic [adp_pkg::SAMPLE_W-1:0] stage_q;

    // Exact address compare, reused for every register.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
        hit = (a == offs);
    endfunction

    assign wr_filter = wr_in && hit(addr_in, adp_pkg::ADDR_FILTER);

    // ========================================================================
    // Register writes; reserved bits are dropped so they read back as zero.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_q    <= adp_pkg::RST_REG;
            filter_q   <= adp_pkg::RST_REG;
            band_q     <= adp_pkg::RST_REG;
            coding_q   <= adp_pkg::RST_REG;
            gain_q     <= {1'b0, adp_pkg::GAIN_UNITY};
            fmt_ctl_q  <= adp_pkg::RST_REG;
            dec_ctl_q  <= adp_pkg::RST_REG;
            band_ctl_q <= adp_pkg::RST_REG;
            gain_ctl_q <= adp_pkg::RST_REG;
        end else if (wr_in) begin
            if (hit(addr_in, adp_pkg::ADDR_RESET)) pulse_q <= wdata_in & adp_pkg::MASK_RESET;
            if (wr_filter) filter_q <= wdata_in & adp_pkg::MASK_FILTER;
            if (hit(addr_in, adp_pkg::ADDR_BAND)) band_q <= wdata_in & adp_pkg::MASK_BAND;
            if (hit(addr_in, adp_pkg::ADDR_CODING)) coding_q <= wdata_in & adp_pkg::MASK_CODING;
            if (hit(addr_in, adp_pkg::ADDR_GAIN)) gain_q <= wdata_in & adp_pkg::MASK_GAIN;
            if (hit(addr_in, adp_pkg::ADDR_FMT_CTL)) fmt_ctl_q <= wdata_in & adp_pkg::MASK_FMT_CTL;
            if (hit(addr_in, adp_pkg::ADDR_DEC_CTL)) dec_ctl_q <= wdata_in & adp_pkg::MASK_DEC_CTL;
            if (hit(addr_in, adp_pkg::ADDR_BAND_CTL)) band_ctl_q <= wdata_in & adp_pkg::MASK_BAND_CTL;
            if (hit(addr_in, adp_pkg::ADDR_GAIN_CTL)) gain_ctl_q <= wdata_in & adp_pkg::MASK_GAIN_CTL;
        end
    end

    // The falling edge of the page reset bit, written 1 then 0, commits settings.
    assign apply = wr_in && hit(addr_in, adp_pkg::ADDR_RESET) && pulse_q[adp_pkg::BIT_PULSE]
                   && !wdata_in[adp_pkg::BIT_PULSE];

    // ========================================================================
    // Active copies change only on the commit, so half-written setups never reach the path.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            a_filter_q  <= adp_pkg::RST_REG;
            a_band_q    <= adp_pkg::RST_REG;
            a_coding_q  <= adp_pkg::RST_REG;
            a_gain_q    <= {1'b0, adp_pkg::GAIN_UNITY};
            a_fmt_en_q  <= 1'b0;
            a_dec_en_q  <= 1'b0;
            a_band_en_q <= 1'b0;
            a_gain_en_q <= 1'b0;
        end else if (apply) begin
            a_filter_q  <= filter_q;
            a_band_q    <= band_q;
            a_coding_q  <= coding_q;
            a_gain_q    <= gain_q;
            a_fmt_en_q  <= fmt_ctl_q[adp_pkg::BIT_FMT_EN];
            a_dec_en_q  <= dec_ctl_q[adp_pkg::BIT_DEC_CTL_EN];
            a_band_en_q <= band_ctl_q[adp_pkg::BIT_BAND_CTL];
            a_gain_en_q <= gain_ctl_q[adp_pkg::BIT_GAIN_EN];
        end
    end

    // ========================================================================
    // Filter selection from the committed shape code.
    assign shape = {a_filter_q[adp_pkg::BIT_SHAPE_TOP], a_filter_q[2:0]};

    always_comb begin
        filt_d  = adp_pkg::ADP_FILT_FULL;
        decim_d = adp_pkg::DECIM_ONE;
        if (a_filter_q[adp_pkg::BIT_RATE_EN]) begin
            // Without shape control the default mode is the first band-pass.
            filt_d  = adp_pkg::ADP_FILT_BP3;
            decim_d = adp_pkg::DECIM_FOUR;
            if (a_dec_en_q) begin
                case (shape)
                    adp_pkg::SHAPE_BP3: filt_d = adp_pkg::ADP_FILT_BP3;
                    adp_pkg::SHAPE_BP5: filt_d = adp_pkg::ADP_FILT_BP5;
                    adp_pkg::SHAPE_BP1: filt_d = adp_pkg::ADP_FILT_BP1;
                    adp_pkg::SHAPE_BP7: filt_d = adp_pkg::ADP_FILT_BP7;
                    adp_pkg::SHAPE_LP: begin
                        filt_d  = adp_pkg::ADP_FILT_LP;
                        decim_d = adp_pkg::DECIM_TWO;
                    end
                    adp_pkg::SHAPE_HP: begin
                        filt_d  = adp_pkg::ADP_FILT_HP;
                        decim_d = adp_pkg::DECIM_TWO;
                    end
                    adp_pkg::SHAPE_LPIQ: filt_d = adp_pkg::ADP_FILT_LPIQ;
                    // Unlisted codes fall back to the default band-pass.
                    default: filt_d = adp_pkg::ADP_FILT_BP3;
                endcase
            end
        end
    end

    // ========================================================================
    // Configuration outputs come from flip-flops.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            filter_sel_out <= 3'h0;
            decim_out      <= adp_pkg::DECIM_ONE;
            band_out       <= adp_pkg::BAND_FIRST;
            band_valid_out <= 1'b0;
            offset_bin_out <= 1'b0;
        end else begin
            filter_sel_out <= filt_d;
            decim_out      <= decim_d;
            // Only the three listed band codes are honoured.
            band_out       <= a_band_q[2:0];
            band_valid_out <= a_band_en_q && (a_band_q[2:0] == adp_pkg::BAND_FIRST ||
                              a_band_q[2:0] == adp_pkg::BAND_SECOND ||
                              a_band_q[2:0] == adp_pkg::BAND_THIRD);
            offset_bin_out <= a_fmt_en_q && a_coding_q[0];
        end
    end

    // ========================================================================
    // Decimation keeps one sample in decim_out; no arithmetic filter is modelled.
    assign keep = (keep_cnt_q == 3'h0);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            keep_cnt_q <= 3'h0;
        end else if (smp_valid_in && smp_ready_out) begin
            keep_cnt_q <= (keep_cnt_q + 3'h1 >= decim_out) ? 3'h0 : keep_cnt_q + 3'h1;
        end
    end

    // Gain is value over 32; the product is saturated to the sample range.
    // Both operands are widened to the product width first, so no bits are dropped or padded silently.
    assign prod = $signed({{7{smp_data_in[adp_pkg::SAMPLE_W-1]}}, smp_data_in})
                  * $signed({14'h0000, a_gain_q[6:0]});

    always_comb begin
        scaled = smp_data_in;
        if (a_gain_en_q) begin
            if ($signed(prod) > $signed({{7{1'b0}}, 1'b0, {(adp_pkg::SAMPLE_W-1){1'b1}}} <<< adp_pkg::GAIN_SHIFT))
                scaled = {1'b0, {(adp_pkg::SAMPLE_W-1){1'b1}}};
            else if ($signed(prod) < -$signed({{7{1'b0}}, 1'b1, {(adp_pkg::SAMPLE_W-1){1'b0}}} <<< adp_pkg::GAIN_SHIFT))
                scaled = {1'b1, {(adp_pkg::SAMPLE_W-1){1'b0}}};
            else
                scaled = prod[adp_pkg::GAIN_SHIFT +: adp_pkg::SAMPLE_W];
        end
    end

    // Offset binary is twos complement with the sign bit flipped.
    assign fmt_smp = {scaled[adp_pkg::SAMPLE_W-1] ^ offset_bin_out, scaled[adp_pkg::SAMPLE_W-2:0]};

    // A register stage; it stalls when the buffer is full so no word is lost.
    assign smp_ready_out = !stage_valid_q || buf_ready;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stage_valid_q <= 1'b0;
            stage_q       <= '0;
        end else if (smp_ready_out) begin
            stage_valid_q <= smp_valid_in && keep;
            stage_q       <= fmt_smp;
        end
    end

    adp_buf2 #(.WIDTH(adp_pkg::SAMPLE_W)) u_buf (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .in_valid_in   (stage_valid_q),
        .in_ready_out  (buf_ready),
        .in_data_in    (stage_q),
        .out_valid_out (out_valid_out),
        .out_ready_in  (out_ready_in),
        .out_data_out  (out_data_out)
    );

    // ========================================================================
    // Read port; unmapped addresses read zero, data stand one cycle after the strobe.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                adp_pkg::ADDR_RESET:    rdata_out <= pulse_q;
                adp_pkg::ADDR_FILTER:   rdata_out <= filter_q;
                adp_pkg::ADDR_BAND:     rdata_out <= band_q;
                adp_pkg::ADDR_CODING:   rdata_out <= coding_q;
                adp_pkg::ADDR_GAIN:     rdata_out <= gain_q;
                adp_pkg::ADDR_FMT_CTL:  rdata_out <= fmt_ctl_q;
                adp_pkg::ADDR_DEC_CTL:  rdata_out <= dec_ctl_q;
                adp_pkg::ADDR_BAND_CTL: rdata_out <= band_ctl_q;
                adp_pkg::ADDR_GAIN_CTL: rdata_out <= gain_ctl_q;
                adp_pkg::ADDR_STATUS:   rdata_out <= {offset_bin_out, band_valid_out, decim_out[2:1], 1'b0, filter_sel_out};
                default:                rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule // adp_digital_path

/* File: tb/adp_digital_path_props.sv */
// Concurrent checks on the ports of the digital path configuration block.
`timescale 1ns/10ps
module adp_digital_path_props (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic [7:0]  addr_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic        out_valid_out,
    input wire logic        out_ready_in,
    input wire logic [13:0] out_data_out,
    input wire logic [2:0]  filter_sel_out,
    input wire logic [2:0]  decim_out,
    input wire logic [2:0]  band_out,
    input wire logic        band_valid_out,
    input wire logic        offset_bin_out
);
    // ========================================================================
    // Shared clock and reset.
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // ========================================================================
    // Mode and rate relations, reserved bits and commit timing.
    a_full_rate: assert property (filter_sel_out == 3'h0 |-> decim_out == 3'h1)
        else $error("full rate path without unit decimation");
    a_bp_four: assert property (filter_sel_out inside {[3'h1:3'h4]} |-> decim_out == 3'h4)
        else $error("band-pass mode not decimating by four");
    a_lp_hp_two: assert property (filter_sel_out inside {3'h5, 3'h6} |-> decim_out == 3'h2)
        else $error("low or high pass mode not decimating by two");
    a_mixer_four: assert property (filter_sel_out == 3'h7 |-> decim_out == 3'h4)
        else $error("mixer mode not decimating by four");
    a_band_code: assert property (band_valid_out |-> band_out <= 3'h2)
        else $error("unused band code marked valid");
    a_commit_only: assert property (!(wr_in && addr_in == 8'h00) ##1 !(wr_in && addr_in == 8'h00)
        |=> $stable(filter_sel_out) && $stable(decim_out) && $stable(offset_bin_out) && $stable(band_valid_out))
        else $error("active setting changed without a page reset pulse");
    a_rsvd_coding: assert property (rd_in && addr_in == 8'h43 |=> rdata_out[7:1] == 7'h00)
        else $error("reserved coding bits read back set");
    a_rsvd_filter: assert property (rd_in && addr_in == 8'h41 |=> rdata_out[7:6] == 2'h0 && !rdata_out[3])
        else $error("reserved filter bits read back set");
    // A stalled receiver must see the same word until it takes it, or a sample is lost.
    a_out_hold: assert property (out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out))
        else $error("output word dropped or changed during stall");
endmodule // adp_digital_path_props

bind adp_digital_path adp_digital_path_props u_props (.clock_in, .rst_in, .addr_in, .wr_in, .rd_in, .rdata_out,
    .out_valid_out, .out_ready_in, .out_data_out, .filter_sel_out, .decim_out, .band_out, .band_valid_out,
    .offset_bin_out);

/* File: tb/test_adc_digital_path_config.sv */
// Self-checking bench for the digital path configuration block.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_adc_digital_path_config;
    logic        clock_in, rst_in, wr_in, rd_in, smp_valid_in, out_ready_in;
    logic [7:0]  addr_in, wdata_in, rdata_out;
    logic [13:0] smp_data_in, out_data_out;
    logic        smp_ready_out, out_valid_out, band_valid_out, offset_bin_out;
    logic [2:0]  filter_sel_out, decim_out, band_out;
    logic [13:0] got_q[$];
    int          n_fail, cmp_count;

    adp_digital_path dut_u (.clock_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .smp_valid_in,
        .smp_ready_out, .smp_data_in, .out_valid_out, .out_ready_in, .out_data_out, .filter_sel_out, .decim_out,
        .band_out, .band_valid_out, .offset_bin_out);

    // ========================================================================
    // Clock and output monitor.
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // Every word taken by the receiver is queued for the scenario in progress.
    always @(posedge clock_in) begin
        if (!rst_in && out_valid_out === 1'b1 && out_ready_in === 1'b1) got_q.push_back(out_data_out);
    end

    // ========================================================================
    // Bus and sample tasks; each ends just after a rising edge with strobes low.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        // Read data stand for one cycle only, so they are judged mid-cycle.
        @(negedge clock_in);
        `CHK(rdata_out, e)
        @(posedge clock_in);
    endtask
    // Pulse the page reset bit so that shadow settings become active.
    task automatic commit();
        wr(8'h00, 8'h01);
        wr(8'h00, 8'h00);
        repeat (2) @(posedge clock_in);
    endtask
    task automatic wait_out(input int n);
        int k;
        k = 0;
        while (got_q.size() < n && k < 20) begin
            @(posedge clock_in);
            k++;
        end
        `CHK(got_q.size(), n)
    endtask
    task automatic chk_smp(input logic [13:0] d, input logic [13:0] e);
        int k;
        got_q.delete();
        smp_data_in  <= d;
        smp_valid_in <= 1'b1;
        k = 0;
        do begin
            @(posedge clock_in);
            k++;
        end while (smp_ready_out !== 1'b1 && k < 20);
        smp_valid_in <= 1'b0;
        wait_out(1);
        `CHK(got_q[0], e)
    endtask
    task automatic set_mode(input logic [7:0] f, input logic [2:0] s, input logic [2:0] r);
        wr(8'h41, f);
        commit();
        `CHK(filter_sel_out, s)
        `CHK(decim_out, r)
    endtask

    // ========================================================================
    // Scenarios.
    task automatic t_reset();
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        rd(8'h43, 8'h00);
        rd(8'h44, 8'h20);
        rd(8'h10, 8'h00);
        `CHK(decim_out, 3'h1)
        `CHK(offset_bin_out, 1'b0)
        `CHK(band_valid_out, 1'b0)
    endtask
    // Fill the stage and buffer with the receiver stalled, then drain in order.
    task automatic t_stall();
        int n;
        got_q.delete();
        out_ready_in <= 1'b0;
        smp_valid_in <= 1'b1;
        smp_data_in  <= 14'h0000;
        n = 0;
        repeat (8) begin
            @(posedge clock_in);
            if (smp_ready_out === 1'b1) begin
                n++;
                smp_data_in <= n[13:0];
            end
        end
        smp_valid_in <= 1'b0;
        out_ready_in <= 1'b1;
        `CHK(n, 3)
        wait_out(3);
        for (int i = 0; i < 3; i++) `CHK(got_q[i], i[13:0])
        repeat (2) @(posedge clock_in);
        `CHK(out_valid_out, 1'b0)
    endtask
    task automatic t_regs();
        wr(8'h41, 8'hFF);
        rd(8'h41, 8'h37);
        wr(8'h42, 8'hFF);
        rd(8'h42, 8'h07);
        wr(8'h43, 8'hFF);
        rd(8'h43, 8'h01);
        wr(8'h44, 8'hFF);
        rd(8'h44, 8'h7F);
        wr(8'h4B, 8'hFF);
        rd(8'h4B, 8'h20);
        wr(8'h4D, 8'hFF);
        rd(8'h4D, 8'h08);
        wr(8'h4E, 8'hFF);
        rd(8'h4E, 8'h80);
        wr(8'h52, 8'hFF);
        rd(8'h52, 8'h01);
        wr(8'h52, 8'h00);
        `CHK(filter_sel_out, 3'h0)
    endtask
    task automatic t_modes();
        logic [3:0] code [7] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2, 4'h6, 4'h3};
        logic [2:0] dec [7]  = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h2, 3'h2, 3'h4};
        wr(8'h4D, 8'h08);
        for (int i = 0; i < 7; i++) set_mode({2'b00, code[i][3], 2'b10, code[i][2:0]}, 3'(i + 1), dec[i]);
        wr(8'h4D, 8'h00);
        commit();
        `CHK(filter_sel_out, 3'h1)
        wr(8'h4D, 8'h08);
        repeat (3) @(posedge clock_in);
        `CHK(filter_sel_out, 3'h1)
        commit();
        `CHK(filter_sel_out, 3'h7)
        set_mode(8'h03, 3'h0, 3'h1);
    endtask
    task automatic t_band();
        logic [2:0] c;
        wr(8'h42, 8'h01);
        wr(8'h4E, 8'h00);
        commit();
        `CHK(band_valid_out, 1'b0)
        wr(8'h4E, 8'h80);
        for (int j = 0; j < 4; j++) begin
            c = (j == 3) ? 3'h5 : 3'(j);
            wr(8'h42, {5'h00, c});
            commit();
            `CHK(band_valid_out, (c < 3'h3))
            if (c < 3'h3) `CHK(band_out, c)
        end
    endtask
    task automatic t_coding();
        wr(8'h43, 8'h01);
        wr(8'h4B, 8'h00);
        commit();
        `CHK(offset_bin_out, 1'b0)
        chk_smp(14'h0005, 14'h0005);
        wr(8'h4B, 8'h20);
        commit();
        `CHK(offset_bin_out, 1'b1)
        rd(8'h60, 8'h80);
        chk_smp(14'h0005, 14'h2005);
        wr(8'h43, 8'h00);
        commit();
        chk_smp(14'h0005, 14'h0005);
    endtask
    task automatic t_gain();
        wr(8'h44, 8'h40);
        commit();
        chk_smp(14'h0005, 14'h0005);
        wr(8'h52, 8'h01);
        commit();
        chk_smp(14'h0005, 14'h000A);
        wr(8'h52, 8'h00);
    endtask
    // Low-pass mode keeps one sample in two.
    task automatic t_decim();
        set_mode(8'h12, 3'h5, 3'h2);
        got_q.delete();
        smp_valid_in <= 1'b1;
        smp_data_in  <= 14'h0001;
        repeat (4) @(posedge clock_in);
        smp_valid_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        `CHK(got_q.size(), 2)
        rd(8'h60, 8'h15);
    endtask

    // ========================================================================
    // Verdict, main sequence and watchdog.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {rst_in, wr_in, rd_in, smp_valid_in, out_ready_in} = 5'b10001;
        {addr_in, wdata_in, smp_data_in} = '0;
        n_fail = 0;
        cmp_count = 0;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        t_reset();
        t_stall();
        t_regs();
        t_modes();
        t_band();
        t_coding();
        t_gain();
        t_decim();
        conclude();
    end
    // The whole sequence needs well under two thousand cycles.
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
endmodule // test_adc_digital_path_config
